// ### ard_defines.svh
`ifndef ARD_DEFINES_SVH
`define ARD_DEFINES_SVH

// ==========================================================================
// widths
`define ARD_RESULT_W        24
`define ARD_RATIO_W         16
`define ARD_BIT_CNT_W       5
`define ARD_GAP_W           4

// ==========================================================================
// modulator divider terminal counts (divide by 2, 4, 16)
`define ARD_DIV_FAST_LAST   4'h1
`define ARD_DIV_MEDIAN_LAST 4'h3
`define ARD_DIV_LOW_LAST    4'hF

// ==========================================================================
// timing
`define ARD_CLK_PERIOD_NS   10
`define ARD_T_MCLK_NS       10
`define ARD_READ_GAP_CYC    ((`ARD_T_MCLK_NS + `ARD_CLK_PERIOD_NS - 1) / `ARD_CLK_PERIOD_NS)

// ==========================================================================
// reset values
`define ARD_RESULT_RESET    24'h000000
`define ARD_RESULT_MSB      23

`endif

// ### ard_pkg.sv
`include "ard_defines.svh"

package ard_pkg;

    typedef enum logic [1:0] {
        ard_mode_fast,
        ard_mode_median,
        ard_mode_low_power
    } ard_power_mode_type;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic serial_data_in;
    } ard_serial_in_type;

    typedef struct packed {
        logic [3:0] count;
        logic       mod_enable;
    } ard_div_state_type;

    typedef struct packed {
        logic [2:0]                  sclk_pipe;
        logic [2:0]                  cs_pipe;
        logic [1:0]                  sdi_pipe;
        logic [2:0]                  start_pipe;
        logic [2:0]                  sync_pipe;
        logic [`ARD_RATIO_W-1:0]     dec_count;
        logic                        busy;
        logic [`ARD_RESULT_W-1:0]    candidate;
        logic                        pending;
        logic                        fire;
        logic [`ARD_GAP_W-1:0]       gap;
        logic [`ARD_RESULT_W-1:0]    result;
        logic                        strobe;
        logic                        ready_low;
        logic                        dout;
        logic                        dout_oe_n;
        logic [`ARD_RESULT_W-1:0]    tx_shift;
        logic [`ARD_RESULT_W-1:0]    rx_shift;
        logic [`ARD_BIT_CNT_W-1:0]   rx_count;
        logic [`ARD_RESULT_W-1:0]    command_word;
        logic                        command_valid;
        logic                        sync_out_n;
        logic                        div_restart;
    } ard_core_state_type;

endpackage

// ### ard_mod_divider.sv
`timescale 1ns/1ns
`include "ard_defines.svh"

module ard_mod_divider (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire ard_pkg::ard_power_mode_type power_mode,
    input  wire logic                    restart,
    output logic                         mod_enable
);
    import ard_pkg::*;

    ard_div_state_type state;
    ard_div_state_type next_state;
    logic [3:0]        last;

    // ======================================================================
    // divide master clock into modulator enable
    always_comb begin
        case (power_mode)
            ard_mode_fast:   last = `ARD_DIV_FAST_LAST;
            ard_mode_median: last = `ARD_DIV_MEDIAN_LAST;
            default:         last = `ARD_DIV_LOW_LAST;
        endcase
        next_state            = state;
        next_state.mod_enable = 1'b0;
        if (restart) begin
            next_state.count = 4'h0;
        end else if (state.count >= last) begin
            next_state.count      = 4'h0;
            next_state.mod_enable = 1'b1;
        end else begin
            next_state.count = state.count + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign mod_enable = state.mod_enable;
endmodule

// ### ard_core.sv
`timescale 1ns/1ns
`include "ard_defines.svh"

// Overview of operation
// - modulator clock divides master; one result per ratio
// - result register updates one clock before strobe
// - single mode strobe waits one clock after read
// - ready indicator pulses one clock, sclk idling high
// - strobe and ready launched on rising master clock
// - alignment output falls three master clocks after sync input rises
// - serial data out changes after falling sclk
// - serial input sampled on rising sclk edges
// - data out enabled by chip select low only
// - ready indicator returns high the clock after sclk rises or is seen high
module ard_core (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire ard_pkg::ard_serial_in_type  serial_in,
    input  wire ard_pkg::ard_power_mode_type power_mode,
    input  wire logic [`ARD_RATIO_W-1:0]     decimation_ratio,
    input  wire logic                        continuous_mode,
    input  wire logic                        ready_on_dout,
    input  wire logic                        start,
    input  wire logic                        sync_in,
    input  wire logic [`ARD_RESULT_W-1:0]    filter_data,
    output logic                             conversion_ready_strobe,
    output logic [`ARD_RESULT_W-1:0]         conversion_result,
    output logic                             serial_data_out,
    output logic                             serial_data_out_oe_n,
    output logic                             sync_out_n,
    output logic [`ARD_RESULT_W-1:0]         command_word,
    output logic                             command_valid
);
    import ard_pkg::*;

    ard_core_state_type state;
    ard_core_state_type next_state;
    logic               mod_enable;
    logic               sclk_rise;
    logic               sclk_fall;
    logic               cs_fall;
    logic               cs_rise;
    logic               start_rise;
    logic               sync_rise;
    logic               selected;
    logic               running;
    logic               conv_event;
    logic               read_gap_ok;
    logic               capture;
    logic               host_rise;

    // ======================================================================
    // edge detection on synchronised levels
    function automatic logic rise(input logic [2:0] pipe);
        rise = pipe[1] & ~pipe[2];
    endfunction

    function automatic logic fall(input logic [2:0] pipe);
        fall = ~pipe[1] & pipe[2];
    endfunction

    // ======================================================================
    // last decimation count; a ratio of zero acts as one
    function automatic logic [`ARD_RATIO_W-1:0] ratio_last(input logic [`ARD_RATIO_W-1:0] ratio);
        if (ratio == '0) begin
            ratio_last = '0;
        end else begin
            ratio_last = ratio - `ARD_RATIO_W'(1);
        end
    endfunction

    // ======================================================================
    // modulator clock enable
    ard_mod_divider ard_mod_divider_inst (
        .clk        (clk),
        .reset      (reset),
        .power_mode (power_mode),
        .restart    (state.div_restart),
        .mod_enable (mod_enable)
    );

    // ======================================================================
    // next state
    always_comb begin
        sclk_rise  = rise(state.sclk_pipe);
        sclk_fall  = fall(state.sclk_pipe);
        cs_fall    = fall(state.cs_pipe);
        cs_rise    = rise(state.cs_pipe);
        start_rise = rise(state.start_pipe);
        sync_rise  = rise(state.sync_pipe);
        selected   = ~state.cs_pipe[1];
        running    = continuous_mode | state.busy;
        conv_event = running & mod_enable &
                     (state.dec_count >= ratio_last(decimation_ratio));
        read_gap_ok = continuous_mode | (state.gap == '0);
        capture     = conv_event & ~sync_rise;
        host_rise   = sclk_rise & selected;

        next_state = state;

        // ==================================================================
        // two-stage synchronisers, third stage for edges
        next_state.sclk_pipe  = {state.sclk_pipe[1:0], serial_in.sclk};
        next_state.cs_pipe    = {state.cs_pipe[1:0], serial_in.cs_n};
        next_state.sdi_pipe   = {state.sdi_pipe[0], serial_in.serial_data_in};
        next_state.start_pipe = {state.start_pipe[1:0], start};
        next_state.sync_pipe  = {state.sync_pipe[1:0], sync_in};

        next_state.fire          = 1'b0;
        next_state.strobe        = 1'b0;
        next_state.command_valid = 1'b0;
        next_state.sync_out_n    = 1'b1;
        next_state.div_restart   = 1'b0;

        // ==================================================================
        // conversion sequencing
        if (sync_rise) begin
            next_state.dec_count   = '0;
            next_state.div_restart = 1'b1;
            next_state.sync_out_n  = 1'b0;
        end else if (conv_event) begin
            next_state.dec_count = '0;
            next_state.candidate = filter_data;
            next_state.pending   = 1'b1;
            if (!continuous_mode) begin
                next_state.busy = 1'b0;
            end
        end else if (running && mod_enable) begin
            next_state.dec_count = state.dec_count + `ARD_RATIO_W'(1);
        end
        if (start_rise && !continuous_mode) begin
            next_state.busy      = 1'b1;
            next_state.dec_count = '0;
        end

        // ==================================================================
        // gap after last rising sclk of a read
        if (host_rise) begin
            next_state.gap = `ARD_GAP_W'(`ARD_READ_GAP_CYC);
        end else if (state.gap != '0) begin
            next_state.gap = state.gap - `ARD_GAP_W'(1);
        end

        // ==================================================================
        // result updates one clock ahead of the strobe
        if (state.pending && read_gap_ok && !(host_rise && !continuous_mode)) begin
            next_state.result  = state.candidate;
            next_state.pending = capture;
            next_state.fire    = 1'b1;
        end

        // ==================================================================
        // strobe one clock after the update
        if (state.fire) begin
            next_state.strobe = 1'b1;
        end

        // ==================================================================
        // serial output
        next_state.dout_oe_n = ~selected;
        if (cs_fall) begin
            next_state.tx_shift = state.result;
            next_state.dout     = state.result[`ARD_RESULT_MSB];
        end else if (state.fire && continuous_mode && ready_on_dout && selected) begin
            next_state.ready_low = 1'b1;
            next_state.dout      = 1'b0;
            next_state.tx_shift  = state.result;
        end else if (state.ready_low && (sclk_rise || state.sclk_pipe[1])) begin
            next_state.ready_low = 1'b0;
            next_state.dout      = 1'b1;
        end else if (sclk_fall && selected && !state.ready_low) begin
            next_state.dout     = state.tx_shift[`ARD_RESULT_MSB];
            next_state.tx_shift = {state.tx_shift[`ARD_RESULT_MSB-1:0], 1'b0};
        end
        if (!selected) begin
            next_state.ready_low = 1'b0;
        end

        // ==================================================================
        // serial input
        if (cs_fall) begin
            next_state.rx_count = '0;
            next_state.rx_shift = '0;
        end else if (host_rise) begin
            next_state.rx_shift = {state.rx_shift[`ARD_RESULT_MSB-1:0], state.sdi_pipe[1]};
            if (state.rx_count != `ARD_BIT_CNT_W'(`ARD_RESULT_W)) begin
                next_state.rx_count = state.rx_count + `ARD_BIT_CNT_W'(1);
            end
        end
        if (cs_rise && state.rx_count != '0) begin
            next_state.command_word  = state.rx_shift;
            next_state.command_valid = 1'b1;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            state            <= '0;
            state.sclk_pipe  <= 3'h7;
            state.cs_pipe    <= 3'h7;
            state.result     <= `ARD_RESULT_RESET;
            state.dout       <= 1'b1;
            state.dout_oe_n  <= 1'b1;
            state.sync_out_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // outputs
    assign conversion_ready_strobe = state.strobe;
    assign conversion_result       = state.result;
    assign serial_data_out         = state.dout;
    assign serial_data_out_oe_n    = state.dout_oe_n;
    assign sync_out_n              = state.sync_out_n;
    assign command_word            = state.command_word;
    assign command_valid           = state.command_valid;
endmodule

// ### ard_core_chk.sv
`timescale 1ns/1ns
module ard_core_chk (
    input logic                       clk,
    input logic                       reset,
    input ard_pkg::ard_serial_in_type serial_in,
    input logic                       continuous_mode,
    input logic                       ready_on_dout,
    input logic                       sync_in,
    input logic                       conversion_ready_strobe,
    input logic [23:0]                conversion_result,
    input logic                       serial_data_out,
    input logic                       serial_data_out_oe_n,
    input logic                       sync_out_n
);
    import ard_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ======================================================
    // strobe and ready
    AST_STROBE_ONE: assert property (
        conversion_ready_strobe |=> !conversion_ready_strobe) else $error("strobe too wide");
    AST_UPDATE_LEAD: assert property (
        $changed(conversion_result) |=> conversion_ready_strobe) else $error("update not led");
    AST_READY_PULSE: assert property (
        continuous_mode && ready_on_dout && !serial_data_out_oe_n && serial_in.sclk
        && $past(serial_in.sclk) && $past(serial_in.sclk, 2) && $rose(conversion_ready_strobe)
        |-> !serial_data_out ##1 serial_data_out) else $error("ready pulse wrong");
    // ======================================================
    // serial port
    AST_OE_OFF: assert property (
        serial_in.cs_n [*4] |-> serial_data_out_oe_n) else $error("output not released");
    AST_OE_ON: assert property (
        !serial_in.cs_n [*4] |-> !serial_data_out_oe_n) else $error("output not enabled");
    AST_DOUT_EDGE: assert property (
        !continuous_mode && !serial_data_out_oe_n && !$past(serial_data_out_oe_n)
        && $changed(serial_data_out) |-> $past(serial_in.sclk, 4) && !$past(serial_in.sclk, 3))
        else $error("data changed off sclk fall");
    // ======================================================
    // alignment output
    AST_SYNC_FALL: assert property (
        $rose(sync_in) |-> ##3 !sync_out_n) else $error("alignment pulse late");
    AST_SYNC_ONE: assert property (
        !sync_out_n |=> sync_out_n) else $error("alignment pulse too wide");
endmodule

// ### ard_host_model.sv
`timescale 1ns/1ns
module ard_host_model (
    input  logic                       clk,
    input  logic                       go,
    input  logic                       hold_cs,
    input  logic [23:0]                tx_word,
    input  logic                       dout,
    output ard_pkg::ard_serial_in_type pins,
    output logic [23:0]                rx_word,
    output logic                       done
);
    import ard_pkg::*;
    initial begin
        pins = 3'b110;
        rx_word = 24'h000000;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                #1 pins.cs_n = 1'b0;
                done = 1'b0;
                for (int i = 23; i >= 0; i--) begin
                    repeat (4) @(posedge clk);
                    #1 pins.sclk = 1'b0;
                    pins.serial_data_in = tx_word[i];
                    repeat (4) @(posedge clk);
                    #1 pins.sclk = 1'b1;
                    rx_word[i] = dout;
                end
                repeat (4) @(posedge clk);
                #1 pins.cs_n = 1'b1;
                pins.serial_data_in = !pins.serial_data_in;
                repeat (4) @(posedge clk);
                #1 done = 1'b1;
            end else begin
                #1 pins.cs_n = !hold_cs;
            end
        end
    end
endmodule

// ### adc_conversion_ready_timing_test.sv
`timescale 1ns/1ns
module adc_conversion_ready_timing_test;
    import ard_pkg::*;
    logic               clk = 1'b0;
    logic               reset = 1'b1;
    ard_power_mode_type mode = ard_mode_fast;
    logic [15:0]        ratio = 16'h0003;
    logic               cont = 1'b1, rdy = 1'b0, start = 1'b0, sync_in = 1'b0;
    logic               go = 1'b0, hold = 1'b0;
    logic [23:0]        fdata = 24'hA5C3E1, tx = 24'h3C5A96, result, cmd, rx;
    logic               strobe, dout, oe_n, sync_n, done, cv;
    ard_serial_in_type  pins;
    int                 error_cnt = 0, compares = 0, n, valid_cnt = 0;
    int                 div_tab[3] = '{2, 4, 16};
    always #5 clk = ~clk;
    ard_core ard_core_inst (.clk(clk), .reset(reset), .serial_in(pins), .power_mode(mode),
        .decimation_ratio(ratio), .continuous_mode(cont), .ready_on_dout(rdy), .start(start),
        .sync_in(sync_in), .filter_data(fdata), .conversion_ready_strobe(strobe),
        .conversion_result(result), .serial_data_out(dout), .serial_data_out_oe_n(oe_n),
        .sync_out_n(sync_n), .command_word(cmd), .command_valid(cv));
    ard_host_model ard_host_model_inst (.clk(clk), .go(go), .hold_cs(hold), .tx_word(tx),
        .dout(dout), .pins(pins), .rx_word(rx), .done(done));
    // ======================================================
    // helpers
    task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wait_strobe;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (strobe !== 1'b1 && n < 400);
        chk("strobe seen", 24'h000001, 24'(strobe));
    endtask
    // ======================================================
    // scenarios
    task test_period;
        for (int m = 0; m < 3; m++) begin
            mode = ard_power_mode_type'(m);
            ratio = 16'(m + 1);
            fdata = 24'hA5C3E0 + 24'(m);
            wait_strobe;
            wait_strobe;
            chk("period", 24'((m + 1) * div_tab[m]), 24'(n));
            chk("result", fdata, result);
        end
    endtask
    task test_single;
        cont = 1'b0;
        tick(60);
        fdata = 24'h96A53C;
        start = 1'b1;
        tick(3);
        start = 1'b0;
        wait_strobe;
        chk("single strobe", 24'h000001, 24'(strobe));
        chk("single result", fdata, result);
        fdata = 24'h000000;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(1);
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
            valid_cnt += (cv === 1'b1);
        end
        chk("read done", 24'h000001, 24'(done));
        chk("command strobe", 24'h000001, 24'(valid_cnt));
        chk("read data", 24'h96A53C, rx);
        chk("held result", 24'h96A53C, result);
        chk("command", tx, cmd);
        chk("released", 24'h000001, 24'(oe_n));
    endtask
    task test_ready;
        cont = 1'b1;
        rdy = 1'b1;
        mode = ard_mode_fast;
        ratio = 16'h0004;
        hold = 1'b1;
        tick(8);
        wait_strobe;
        chk("ready low", 24'h000000, 24'(dout));
        tick(1);
        chk("ready high", 24'h000001, 24'(dout));
        hold = 1'b0;
        rdy = 1'b0;
    endtask
    task test_sync;
        sync_in = 1'b1;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            if (i == 2) sync_in = 1'b0;
            n += (sync_n === 1'b0);
        end
        chk("sync pulses", 24'h000001, 24'(n));
    endtask
    task end_of_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(6);
        reset = 1'b0;
        tick(4);
        test_period;
        test_single;
        test_ready;
        test_sync;
        end_of_test;
    end
    initial begin
        #200000;
        error_cnt++;
        end_of_test;
    end
endmodule
bind ard_core ard_core_chk ard_core_chk_inst (.clk(clk), .reset(reset), .serial_in(serial_in),
    .continuous_mode(continuous_mode), .ready_on_dout(ready_on_dout), .sync_in(sync_in),
    .conversion_ready_strobe(conversion_ready_strobe), .conversion_result(conversion_result),
    .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n),
    .sync_out_n(sync_out_n));
